//--- verif/dram_strobe_and_select_pins_bench.sv
`timescale 1ns/1ps
module dram_strobe_and_select_pins_bench;
    logic core_clk = 1'b0, nrst = 1'b0, acc_req = 1'b0, acc_read = 1'b0, refresh_req = 1'b0, row_addr_mode = 1'b0;
    logic [1:0] acc_byte_en = 2'h0;
    logic [23:0] acc_addr = 24'h000000;
    logic [7:0] test_config_reg = 8'h00;
    logic cycle_done, col_strobe_upper_n, col_strobe_lower_n, row_strobe_first_n, row_strobe_second_n;
    logic row_col_select, dram_read_write, rom_select_n;
    logic [7:0] first_cnt, second_cnt, refresh_cnt;
    int n_fail = 0, checked = 0;
    always #5 core_clk = ~core_clk;
    dsp_strobes u_dut (.core_clk, .nrst, .acc_req, .acc_read, .acc_byte_en, .acc_addr, .refresh_req, .cycle_done,
        .row_addr_mode, .test_config_reg, .col_strobe_upper_n, .col_strobe_lower_n, .row_strobe_first_n,
        .row_strobe_second_n, .row_col_select, .dram_read_write, .rom_select_n);
    dsp_dram_model u_mem (.core_clk, .row_strobe_first_n, .row_strobe_second_n, .col_strobe_lower_n,
        .first_cnt, .second_cnt, .refresh_cnt);
    task automatic report_and_stop;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bounded wait for done, then the gap the next request needs
    task automatic wait_done;
        for (int i = 0; i < 20 && cycle_done !== 1'b1; i++) @(posedge core_clk) #1;
        if (cycle_done !== 1'b1)
        begin
            n_fail++;
            report_and_stop();
        end
        @(posedge core_clk);
        {acc_req, refresh_req} <= 2'h0;
        repeat (3) @(posedge core_clk);
    endtask
    // One access; column phase sampled three edges after take
    task automatic dram_cycle(input logic rd, input logic [1:0] be, input logic [23:0] a, input logic [7:0] df, ds);
        logic [7:0] f0, s0;
        logic       ra;
        f0 = first_cnt;
        s0 = second_cnt;
        @(posedge core_clk);
        {acc_req, acc_read, acc_byte_en, acc_addr} <= {1'b1, rd, be, a};
        repeat (4) @(posedge core_clk) #1;
        chk({6'h0, col_strobe_upper_n, col_strobe_lower_n}, {6'h0, ~be});
        chk({7'h0, dram_read_write}, {7'h0, rd});
        // Upper pin is an address line in extra mode, so its level matters, not its edges
        ra = row_strobe_second_n;
        wait_done();
        chk(first_cnt - f0, df);
        if (row_addr_mode)
            chk({7'h0, ra}, {7'h0, a[22]});
        else
            chk(second_cnt - s0, ds);
    endtask
    // Refresh with the generic read line low
    task automatic refresh_cycle;
        logic [7:0] r0, f0, s0;
        {r0, f0, s0} = {refresh_cnt, first_cnt, second_cnt};
        @(posedge core_clk);
        {refresh_req, acc_read} <= 2'h2;
        repeat (2) @(posedge core_clk) #1;
        chk({6'h0, col_strobe_upper_n, col_strobe_lower_n}, 8'h00);
        chk({7'h0, dram_read_write}, 8'h01);
        wait_done();
        chk(refresh_cnt - r0, 8'h01);
        chk(first_cnt - f0, 8'h01);
        chk(second_cnt - s0, 8'h01);
    endtask
    // Single-cycle ROM request
    task automatic rom_try(input logic rd, input logic [23:0] a, input logic rom_exp);
        @(posedge core_clk);
        {acc_req, acc_read, acc_addr} <= {1'b1, rd, a};
        @(posedge core_clk);
        acc_req <= 1'b0;
        #1 chk({7'h0, rom_select_n}, {7'h0, rom_exp});
        @(posedge core_clk) #1 chk({7'h0, rom_select_n}, 8'h01);
    endtask
    initial
    begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        dram_cycle(1'b1, 2'h3, 24'h000100, 8'h01, 8'h00);
        dram_cycle(1'b0, 2'h2, 24'h400200, 8'h00, 8'h01);
        dram_cycle(1'b1, 2'h1, 24'hefffff, 8'h00, 8'h01);
        refresh_cycle();
        rom_try(1'b1, 24'hf00000, 1'b0);
        rom_try(1'b0, 24'hffffff, 1'b1);
        @(posedge core_clk);
        test_config_reg <= 8'h40;
        dram_cycle(1'b1, 2'h3, 24'h000000, 8'h00, 8'h01);
        dram_cycle(1'b0, 2'h3, 24'h400000, 8'h01, 8'h00);
        {test_config_reg, row_addr_mode} <= 9'h001;
        dram_cycle(1'b1, 2'h3, 24'h400000, 8'h01, 8'h00);
        dram_cycle(1'b1, 2'h3, 24'h000000, 8'h01, 8'h01);
        report_and_stop();
    end
endmodule

//--- verif/dsp_dram_model.sv
`timescale 1ns/1ps
module dsp_dram_model (
    // Clock and strobes
    input wire logic   core_clk,
    input wire logic   row_strobe_first_n,
    input wire logic   row_strobe_second_n,
    input wire logic   col_strobe_lower_n,
    // Strobes each row has latched
    output logic [7:0] first_cnt,
    output logic [7:0] second_cnt,
    output logic [7:0] refresh_cnt
);
    logic [2:0] prev_reg;
    initial
    begin
        {first_cnt, second_cnt, refresh_cnt} = 24'h000000;
        prev_reg = 3'h7;
    end
    // Rows latch on falling edges; column before row means refresh
    always @(posedge core_clk)
    begin
        if (prev_reg[0] && !row_strobe_first_n) first_cnt <= first_cnt + 8'h01;
        if (prev_reg[1] && !row_strobe_second_n) second_cnt <= second_cnt + 8'h01;
        if (prev_reg[2] && !col_strobe_lower_n && row_strobe_first_n) refresh_cnt <= refresh_cnt + 8'h01;
        prev_reg <= {col_strobe_lower_n, row_strobe_second_n, row_strobe_first_n};
    end
endmodule

//--- verif/dsp_strobes_monitor.sv
`timescale 1ns/1ps
module dsp_strobes_monitor (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        nrst,
    // Request and configuration
    input wire logic        acc_req,
    input wire logic        acc_read,
    input wire logic [1:0]  acc_byte_en,
    input wire logic [23:0] acc_addr,
    input wire logic        cycle_done,
    input wire logic        row_addr_mode,
    input wire logic [7:0]  test_config_reg,
    // Memory pins
    input wire logic        col_strobe_upper_n,
    input wire logic        col_strobe_lower_n,
    input wire logic        row_strobe_first_n,
    input wire logic        row_strobe_second_n,
    input wire logic        row_col_select,
    input wire logic        dram_read_write,
    input wire logic        rom_select_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Default pin map only; swapped or extra-bit maps reuse the pins
    wire logic plain_map = !row_addr_mode && !test_config_reg[dsp_pkg::SWAP_BIT];
    wire logic cas_off = col_strobe_upper_n && col_strobe_lower_n;
    // Row strobe falling with column strobes idle starts an access
    sequence s_acc;
        $fell(row_strobe_first_n) && cas_off && plain_map;
    endsequence
    a_rom_select: assert property (rom_select_n == !$past(acc_req && acc_read && acc_addr >= dsp_pkg::ROM_LO))
        else $error("rom select wrong");
    a_col_phase: assert property (s_acc |-> row_col_select ##1 cas_off ##1 !row_col_select &&
        col_strobe_upper_n == !acc_byte_en[1] && col_strobe_lower_n == !acc_byte_en[0] && dram_read_write == acc_read)
        else $error("column phase wrong");
    a_done_timing: assert property (s_acc |-> !cycle_done [*5] ##1 cycle_done)
        else $error("done timing wrong");
    a_rw_refresh: assert property (!col_strobe_lower_n && row_strobe_first_n && row_strobe_second_n
        && !row_addr_mode |-> dram_read_write) else $error("rw low in refresh");
    a_ras_hold: assert property ($fell(row_strobe_first_n) && !row_addr_mode |-> !row_strobe_first_n [*3])
        else $error("row strobe short");
    a_cas_hold: assert property ($fell(col_strobe_upper_n) |-> !col_strobe_upper_n [*3])
        else $error("column strobe short");
    a_done_idle: assert property (cycle_done && !row_addr_mode |-> cas_off && row_strobe_first_n
        && row_strobe_second_n && row_col_select) else $error("pins busy at done");
    a_second_row: assert property ($fell(row_strobe_second_n) && cas_off && plain_map
        |-> acc_addr[dsp_pkg::ROW_ADDR_BIT]) else $error("wrong row");
    // Main scenarios reached
    c_second: cover property ($fell(row_strobe_second_n));
    c_refresh: cover property (!col_strobe_lower_n && row_strobe_first_n && row_strobe_second_n);
    c_rom: cover property (!rom_select_n);
endmodule
bind dsp_strobes dsp_strobes_monitor u_mon (.core_clk, .nrst, .acc_req, .acc_read, .acc_byte_en, .acc_addr,
    .cycle_done, .row_addr_mode, .test_config_reg, .col_strobe_upper_n, .col_strobe_lower_n,
    .row_strobe_first_n, .row_strobe_second_n, .row_col_select, .dram_read_write, .rom_select_n);

//--- verilog/dsp_pkg.sv
// Summary of operation
// - Upper column strobe serves high byte, lower column strobe serves low byte.
// - Both column strobes are asserted during refresh cycles too.
// - Row/column select is high for row address, low for column address.
// - Dedicated DRAM read/write line controls all DRAM devices on accesses.
// - DRAM read/write line stays high for the whole refresh cycle.
// - Two row strobes: first row on lower strobe, optional second row upper.
// - Row strobes are asserted during refresh as well as normal accesses.
// - Upper row strobe is second-row strobe by default, else extra address bit.
// - Extra address bit mode serves one row of 4M-bit parts filling 8M bytes.
// - Test config bit 6 swaps the two row strobe pins; clear keeps default.
// - ROM select low only on reads from F00000 through FFFFFF.
package dsp_pkg;
    // Address and control field positions
    localparam int          ADDR_W        = 24;
    localparam int          ROW_ADDR_BIT  = 22;
    localparam int          SWAP_BIT      = 6;
    localparam logic [23:0] ROM_LO        = 24'hf00000;
    localparam logic [23:0] ROM_HI        = 24'hffffff;
    // Phase lengths in cycles at 100 MHz
    localparam int          ROW_CYC       = 2;
    localparam int          COL_CYC       = 3;
    localparam int          PRE_CYC       = 2;
    localparam logic [2:0]  ROW_CNT       = 3'(ROW_CYC - 1);
    localparam logic [2:0]  COL_CNT       = 3'(COL_CYC - 1);
    localparam logic [2:0]  PRE_CNT       = 3'(PRE_CYC - 1);
    typedef enum logic [2:0] {ST_IDLE, ST_ROW, ST_COL, ST_RF_CAS, ST_RF_RAS, ST_PRE} dsp_state_e;
endpackage

//--- verilog/dsp_strobes.sv
`timescale 1ns/1ps
module dsp_strobes
(
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       nrst,
    // Request from the controller core
    input  wire logic                       acc_req,
    input  wire logic                       acc_read,
    input  wire logic [1:0]                 acc_byte_en,
    input  wire logic [dsp_pkg::ADDR_W-1:0] acc_addr,
    input  wire logic                       refresh_req,
    output logic                            cycle_done,
    // Configuration bits
    input  wire logic                       row_addr_mode,
    input  wire logic [7:0]                 test_config_reg,
    // DRAM and ROM pins
    output logic                            col_strobe_upper_n,
    output logic                            col_strobe_lower_n,
    output logic                            row_strobe_first_n,
    output logic                            row_strobe_second_n,
    output logic                            row_col_select,
    output logic                            dram_read_write,
    output logic                            rom_select_n
);
    dsp_pkg::dsp_state_e state_reg, state_next;
    logic [2:0] cnt_reg, cnt_next;
    logic       rd_reg, rd_next;
    logic [1:0] be_reg, be_next;
    logic       row2_reg, row2_next;
    logic       casu_reg, casu_next, col_strobe_lower_n_reg, col_strobe_lower_n_next;
    logic       ras1_reg, ras1_next, ras2_reg, ras2_next;
    logic       sel_reg, sel_next, rw_reg, rw_next, rom_reg, rom_next;
    logic       done_reg, done_next;
    logic       in_rom;
    logic       swap;
    logic       pin_a, pin_b;

    assign in_rom = (acc_addr >= dsp_pkg::ROM_LO) && (acc_addr <= dsp_pkg::ROM_HI);
    assign swap   = test_config_reg[dsp_pkg::SWAP_BIT];

    // Sequencer; refresh wins over access when both wait
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        rd_next    = rd_reg;
        be_next    = be_reg;
        row2_next  = row2_reg;
        done_next  = 1'b0;
        unique case (state_reg)
            dsp_pkg::ST_IDLE:
            begin
                if (refresh_req)
                begin
                    state_next = dsp_pkg::ST_RF_CAS;
                    cnt_next   = dsp_pkg::ROW_CNT;
                end
                else if (acc_req && !in_rom)
                begin
                    state_next = dsp_pkg::ST_ROW;
                    cnt_next   = dsp_pkg::ROW_CNT;
                    rd_next    = acc_read;
                    be_next    = acc_byte_en;
                    row2_next  = acc_addr[dsp_pkg::ROW_ADDR_BIT];
                end
            end
            dsp_pkg::ST_ROW:
            begin
                cnt_next = cnt_reg - 3'h1;
                if (cnt_reg == 3'h0)
                begin
                    state_next = dsp_pkg::ST_COL;
                    cnt_next   = dsp_pkg::COL_CNT;
                end
            end
            dsp_pkg::ST_COL, dsp_pkg::ST_RF_RAS:
            begin
                cnt_next = cnt_reg - 3'h1;
                if (cnt_reg == 3'h0)
                begin
                    state_next = dsp_pkg::ST_PRE;
                    cnt_next   = dsp_pkg::PRE_CNT;
                    done_next  = 1'b1;
                end
            end
            dsp_pkg::ST_RF_CAS:
            begin
                cnt_next = cnt_reg - 3'h1;
                if (cnt_reg == 3'h0)
                begin
                    state_next = dsp_pkg::ST_RF_RAS;
                    cnt_next   = dsp_pkg::COL_CNT;
                end
            end
            dsp_pkg::ST_PRE:
            begin
                cnt_next = cnt_reg - 3'h1;
                if (cnt_reg == 3'h0)
                    state_next = dsp_pkg::ST_IDLE;
            end
            default:
                state_next = dsp_pkg::ST_IDLE;
        endcase
    end

    // Pin values, registered so outputs are glitch free
    always_comb
    begin
        pin_a     = 1'b1;
        pin_b     = 1'b1;
        casu_next = 1'b1;
        col_strobe_lower_n_next = 1'b1;
        sel_next  = 1'b1;
        rw_next   = 1'b1;
        unique case (state_next)
            dsp_pkg::ST_ROW:
            begin
                pin_a   = row2_next | row_addr_mode;
                pin_b   = ~row2_next | row_addr_mode;
                rw_next = rd_next;
            end
            dsp_pkg::ST_COL:
            begin
                pin_a     = row2_reg | row_addr_mode;
                pin_b     = ~row2_reg | row_addr_mode;
                sel_next  = 1'b0;
                casu_next = ~be_reg[1];
                col_strobe_lower_n_next = ~be_reg[0];
                rw_next   = rd_reg;
            end
            dsp_pkg::ST_RF_CAS:
            begin
                casu_next = 1'b0;
                col_strobe_lower_n_next = 1'b0;
            end
            dsp_pkg::ST_RF_RAS:
            begin
                casu_next = 1'b0;
                col_strobe_lower_n_next = 1'b0;
                pin_a     = 1'b0;
                pin_b     = row_addr_mode; // Address bit is not a strobe
            end
            default:
            begin
                // Extra address bit rests low in idle and precharge
                pin_b = row_addr_mode ? 1'b0 : 1'b1;
            end
        endcase
        // Extra address bit carries the upper row address in that mode
        if (row_addr_mode && (state_next == dsp_pkg::ST_ROW || state_next == dsp_pkg::ST_COL))
            pin_b = (state_next == dsp_pkg::ST_ROW) ? row2_next : row2_reg;
        if (row_addr_mode && (state_next == dsp_pkg::ST_ROW || state_next == dsp_pkg::ST_COL))
            pin_a = 1'b0;
        // Refresh keeps the line at read level throughout
        if (state_next == dsp_pkg::ST_RF_CAS || state_next == dsp_pkg::ST_RF_RAS)
            rw_next = 1'b1;
        ras1_next = swap ? pin_b : pin_a;
        ras2_next = swap ? pin_a : pin_b;
        rom_next  = ~(acc_req && acc_read && in_rom);
    end

    // State and pin registers
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= dsp_pkg::ST_IDLE;
            cnt_reg   <= 3'h0;
            rd_reg    <= 1'b1;
            be_reg    <= 2'h0;
            row2_reg  <= 1'b0;
            casu_reg  <= 1'b1;
            col_strobe_lower_n_reg  <= 1'b1;
            ras1_reg  <= 1'b1;
            ras2_reg  <= 1'b1;
            sel_reg   <= 1'b1;
            rw_reg    <= 1'b1;
            rom_reg   <= 1'b1;
            done_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            rd_reg    <= rd_next;
            be_reg    <= be_next;
            row2_reg  <= row2_next;
            casu_reg  <= casu_next;
            col_strobe_lower_n_reg  <= col_strobe_lower_n_next;
            ras1_reg  <= ras1_next;
            ras2_reg  <= ras2_next;
            sel_reg   <= sel_next;
            rw_reg    <= rw_next;
            rom_reg   <= rom_next;
            done_reg  <= done_next;
        end
    end

    // Outputs straight from flip-flops
    assign col_strobe_upper_n  = casu_reg;
    assign col_strobe_lower_n  = col_strobe_lower_n_reg;
    assign row_strobe_first_n  = ras1_reg;
    assign row_strobe_second_n = ras2_reg;
    assign row_col_select      = sel_reg;
    assign dram_read_write     = rw_reg;
    assign rom_select_n        = rom_reg;
    assign cycle_done          = done_reg;
endmodule
